// *** rtl/icsd_cmd.v ***
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "icsd_cmd_regs.vh"
module icsd_cmd #(
    parameter DATA_WIDTH = 32
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [DATA_WIDTH-1:0] pwdata,
    output wire pready,
    output wire [DATA_WIDTH-1:0] prdata,
    output wire pslverr,
    // Pending register contents from the core
    input wire [DATA_WIDTH-1:0] pendingValue,
    // Commands to the interrupt core
    output wire [DATA_WIDTH-1:0] channelClearBits,
    output wire serviceDone,
    output wire pendingClear,
    output wire stackRequest,
    output wire debugMode
);

    localparam [DATA_WIDTH-1:0] ZERO_WORD = {DATA_WIDTH{1'b0}};

    // Access handshake state
    reg ackPending_q;
    reg ackPending_d;

    // Debug mode bit
    reg debugMode_q;
    reg debugMode_d;

    // Command pulses
    reg [DATA_WIDTH-1:0] channelClear_q;
    reg [DATA_WIDTH-1:0] channelClear_d;
    reg serviceDone_q;
    reg serviceDone_d;
    reg pendingClear_q;
    reg pendingClear_d;
    reg stackRequest_q;
    reg stackRequest_d;

    // Read data
    reg [DATA_WIDTH-1:0] readData_q;
    reg [DATA_WIDTH-1:0] readData_d;

    // Bus qualifiers
    wire access;
    wire firstAccess;
    wire wrDone;
    wire rdDone;

    // Address hits
    wire hitClear;
    wire hitEos;
    wire hitDebug;
    wire hitPending;

    // Exact word match; partial decoding would alias the commands elsewhere
    function addrHit;
        input [31:0] addr;
        input [31:0] target;
        begin
            addrHit = (addr == target);
        end
    endfunction

    // Bit 0 never names a channel
    function [DATA_WIDTH-1:0] clearMask;
        input [DATA_WIDTH-1:0] data;
        begin
            clearMask = data;
            clearMask[0] = 1'b0;
        end
    endfunction

    // Only the pending register reads back; every command register reads zero
    function [DATA_WIDTH-1:0] readSelect;
        input isRead;
        input isPending;
        input [DATA_WIDTH-1:0] pendValue;
        begin
            if (isRead && isPending) begin
                readSelect = pendValue;
            end else begin
                readSelect = ZERO_WORD;
            end
        end
    endfunction

    assign hitClear = addrHit(paddr, `ICSD_ADDR_CLEAR);
    assign hitEos = addrHit(paddr, `ICSD_ADDR_EOS);
    assign hitDebug = addrHit(paddr, `ICSD_ADDR_DEBUG);
    assign hitPending = addrHit(paddr, `ICSD_ADDR_PENDING);

    // One wait state lets registered read data stand at the completing edge
    assign access = psel & penable;
    assign firstAccess = access & ~ackPending_q;
    assign pready = access & ackPending_q;
    assign pslverr = 1'b0;
    assign wrDone = pready & pwrite;
    assign rdDone = pready & ~pwrite;

    assign prdata = readData_q;
    assign channelClearBits = channelClear_q;
    assign serviceDone = serviceDone_q;
    assign pendingClear = pendingClear_q;
    assign stackRequest = stackRequest_q;
    assign debugMode = debugMode_q;

    always @* begin
        ackPending_d = firstAccess;
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            ackPending_q <= 1'b0;
        end else begin
            ackPending_q <= ackPending_d;
        end
    end

    always @* begin
        debugMode_d = debugMode_q;
        if (wrDone && hitDebug) begin
            debugMode_d = pwdata[`ICSD_DEBUG_BIT];
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            debugMode_q <= `ICSD_DEBUG_RESET;
        end else begin
            debugMode_q <= debugMode_d;
        end
    end

    always @* begin
        channelClear_d = ZERO_WORD;
        if (wrDone && hitClear) begin
            channelClear_d = clearMask(pwdata);
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            channelClear_q <= ZERO_WORD;
        end else begin
            channelClear_q <= channelClear_d;
        end
    end

    // The data word is ignored: any write ends the service
    always @* begin
        serviceDone_d = 1'b0;
        if (wrDone && hitEos) begin
            serviceDone_d = 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            serviceDone_q <= 1'b0;
        end else begin
            serviceDone_q <= serviceDone_d;
        end
    end

    // Clearing follows the completed read, so the bus sees the old contents
    always @* begin
        pendingClear_d = 1'b0;
        if (rdDone && hitPending) begin
            pendingClear_d = ~debugMode_q;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            pendingClear_q <= 1'b0;
        end else begin
            pendingClear_q <= pendingClear_d;
        end
    end

    // In normal mode a write here does nothing
    always @* begin
        stackRequest_d = 1'b0;
        if (wrDone && hitPending) begin
            stackRequest_d = debugMode_q;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            stackRequest_q <= 1'b0;
        end else begin
            stackRequest_q <= stackRequest_d;
        end
    end

    // Loaded in the wait cycle and held through the completing edge
    always @* begin
        readData_d = readData_q;
        if (firstAccess) begin
            readData_d = readSelect(~pwrite, hitPending, pendingValue);
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            readData_q <= ZERO_WORD;
        end else begin
            readData_q <= readData_d;
        end
    end

endmodule // icsd_cmd

// *** rtl/icsd_cmd_regs.vh ***
// Operation
// - Writing one in bits 31..1 deactivates channel
// - Zero bits and bit 0 change nothing
// - Any write to end-of-service signals service done
// - Debug bit 0: pending register read clears it
// - Debug bit 1: pending write performs stacking
`ifndef ICSD_CMD_REGS_VH
`define ICSD_CMD_REGS_VH
`define ICSD_ADDR_CLEAR 32'hFFF8_212C
`define ICSD_ADDR_EOS 32'hFFF8_2130
`define ICSD_ADDR_DEBUG 32'hFFF8_2200
`define ICSD_ADDR_PENDING 32'hFFF8_2108
`define ICSD_DEBUG_BIT 0
`define ICSD_DEBUG_RESET 1'b0
`define ICSD_CLEAR_MASK 32'hFFFF_FFFE
`define ICSD_ZERO 32'h0000_0000
`endif

// *** testbench/icsd_cmd_monitor.sv ***
`timescale 1ns/1ps
`include "icsd_cmd_regs.vh"
module icsd_cmd_monitor(input wire ref_clk,resetn,psel,penable,pwrite,pready,serviceDone,
    pendingClear,stackRequest,debugMode,
    input wire [31:0] paddr,pwdata,prdata,channelClearBits,pendingValue);
wire w=psel&penable&pready&pwrite,r=psel&penable&pready&!pwrite;
wire c=paddr==`ICSD_ADDR_CLEAR,e=paddr==`ICSD_ADDR_EOS,p=paddr==`ICSD_ADDR_PENDING;
default clocking @(posedge ref_clk); endclocking
default disable iff (!resetn);
sequence s_wait;
    psel&&penable&&!pready;
endsequence
sequence s_done;
    psel&&penable&&pready;
endsequence
a_clr_bits: assert property (w&&c|=>channelClearBits==($past(pwdata)&`ICSD_CLEAR_MASK))
    else $error("clear");
a_clr_idle: assert property (!(w&&c)|=>channelClearBits==0) else $error("idle");
a_eos_go: assert property (w&&e|=>serviceDone) else $error("eos");
a_eos_idle: assert property (!(w&&e)|=>!serviceDone) else $error("eos idle");
a_pend_clr: assert property (r&&p|=>pendingClear!=$past(debugMode)) else $error("pc");
a_pend_stack: assert property (w&&p|=>stackRequest==$past(debugMode)) else $error("sr");
a_dbg_bit: assert property (w&&paddr==`ICSD_ADDR_DEBUG|=>debugMode==$past(pwdata[0]))
    else $error("dbg");
a_cmd_rd: assert property (r&&(c||e)|->prdata==0) else $error("rd");
a_pend_data: assert property (s_wait ##1 s_done and r&&p |-> prdata==$past(pendingValue))
    else $error("pend data");
a_wait_one: assert property (s_wait |=> pready) else $error("wait");
endmodule // icsd_cmd_monitor
bind icsd_cmd icsd_cmd_monitor u_mon(.*);

// *** testbench/icsd_cmd_bench.sv ***
`timescale 1ns/1ps
`include "icsd_cmd_regs.vh"
`define CK(a,b) begin tests_run++; if((a)!==(b)) begin num_errors++; $display("CHECK FAILED %0t %h %h",$time,a,b); end end
module icsd_cmd_bench;
reg ref_clk=0,resetn=0,psel=0,penable=0,pwrite=0;
reg [31:0] paddr=0,pwdata=0,pv=32'h0000_00A5;
wire [31:0] prdata,cb;
wire rdy,sd,pc,sr,dm;
int num_errors=0,tests_run=0;
icsd_cmd u_icsd_cmd(.ref_clk,.resetn,.psel,.penable,.pwrite,.paddr,.pwdata,.pready(rdy),.prdata,
    .pslverr(),.pendingValue(pv),.channelClearBits(cb),.serviceDone(sd),.pendingClear(pc),
    .stackRequest(sr),.debugMode(dm));
initial forever #4 ref_clk=~ref_clk;
// One APB access; read data is taken at the negedge before the completing edge, pulses judged just after that edge
task t(input [31:0] a,d,input w,input [67:0] x);
    integer n;
    reg [31:0] rd;
    begin
        n=0;
        @(posedge ref_clk) {psel,paddr,pwdata,pwrite}<={1'b1,a,d,w};
        @(posedge ref_clk) penable<=1;
        @(negedge ref_clk);
        while(!rdy&&n<16) begin
            n=n+1;
            @(negedge ref_clk);
        end
        if(!rdy) begin
            num_errors++;
            print_verdict;
        end else begin
            `CK(rdy,1'b1)
            rd=prdata;
            @(posedge ref_clk) {psel,penable}<=0;
            #1 `CK({cb,sd,pc,sr,dm,rd},x)
        end
    end
endtask
// Reset in mid-run must drop debug mode and every pulse
task reset_mid;
    begin
        @(posedge ref_clk) resetn<=0;
        repeat(2) @(posedge ref_clk);
        #1 `CK({cb,sd,pc,sr,dm,prdata},68'h0)
        @(posedge ref_clk) resetn<=1;
    end
endtask
task print_verdict;
    $display("errors %0d checks %0d",num_errors,tests_run);
    if(num_errors==0&&tests_run>0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
initial begin
    repeat(12) @(posedge ref_clk);
    resetn<=1;
    t(`ICSD_ADDR_CLEAR,32'hFFFF_FFFF,1,{32'hFFFF_FFFE,36'h0});
    t(`ICSD_ADDR_CLEAR,32'h0000_0001,1,68'h0);
    t(`ICSD_ADDR_EOS,32'h1234_5678,1,{32'h0,4'h8,32'h0});
    t(`ICSD_ADDR_PENDING,0,1,68'h0);
    t(`ICSD_ADDR_PENDING,0,0,{32'h0,4'h4,pv});
    t(`ICSD_ADDR_DEBUG,32'hFFFF_FFFF,1,{32'h0,4'h1,32'h0});
    t(`ICSD_ADDR_PENDING,0,0,{32'h0,4'h1,pv});
    t(`ICSD_ADDR_PENDING,0,1,{32'h0,4'h3,32'h0});
    t(`ICSD_ADDR_EOS,0,0,{32'h0,4'h1,32'h0});
    t(`ICSD_ADDR_CLEAR,0,0,{32'h0,4'h1,32'h0});
    reset_mid;
    t(`ICSD_ADDR_DEBUG,32'h0000_0001,1,{32'h0,4'h1,32'h0});
    t(`ICSD_ADDR_DEBUG,32'hFFFF_FFFE,1,68'h0);
    print_verdict;
end
endmodule // icsd_cmd_bench
